//--- core/fca_pkg.sv
// package for the flash command host controller: register map, command codes, timing counts
package fca_pkg;
  // apb register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_PINS = 8'h14;
  // control field positions
  localparam int CTRL_GO_LSB = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_OP_W = 3;
  localparam int CTRL_WORD_BIT = 4;
  // pins register field positions
  localparam int PINS_RST_BIT = 0;
  localparam int PINS_A9HV_BIT = 1;
  localparam int PINS_RSTHV_BIT = 2;
  // status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_FLAG_BIT = 2;
  localparam int STAT_PROT_BIT = 3;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0010;
  localparam logic [31:0] PINS_RST = 32'h0000_0001;
  // flash bus widths
  localparam int AW = 20;
  localparam int DW = 16;
  // command cycle values
  localparam logic [15:0] UNLOCK1_ADDR = 16'h0555;
  localparam logic [15:0] UNLOCK2_ADDR = 16'h02AA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  // identification offsets
  localparam logic [7:0] ID_MAN_OFS = 8'h00;
  localparam logic [7:0] ID_DEV_OFS_WORD = 8'h01;
  localparam logic [7:0] ID_DEV_OFS_BYTE = 8'h02;
  localparam logic [7:0] ID_PROT_OFS_WORD = 8'h02;
  localparam logic [7:0] ID_PROT_OFS_BYTE = 8'h04;
  localparam logic [7:0] ID_PROT_YES = 8'h01;
  // strobe phase length in ns and cycles (least time, rounded up)
  localparam int CLK_NS = 10;
  localparam int PHASE_NS = 40;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  // host operations
  typedef enum logic [2:0] {
    FCA_OP_READ,
    FCA_OP_WRITE,
    FCA_OP_RESET_CMD,
    FCA_OP_IDENT_ENTER,
    FCA_OP_IDENT_READ
  } fca_op_t;
  // strobes toward the flash
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic reset_n;
    logic a9_hv;
    logic reset_hv;
  } fca_strobe_t;
endpackage : fca_pkg

//--- core/fca_cycle.sv
// one flash bus cycle: read or write with strobe timing
`timescale 1ns/1ps
module fca_cycle (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic is_write,
  input wire logic [fca_pkg::AW-1:0] addr,
  input wire logic [fca_pkg::DW-1:0] wdata,
  input wire logic [fca_pkg::DW-1:0] dq_in,
  output logic busy,
  output logic done,
  output logic [fca_pkg::DW-1:0] rdata,
  output logic [fca_pkg::AW-1:0] fl_addr,
  output logic [fca_pkg::DW-1:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} fca_cy_t;
  fca_cy_t state;
  logic [fca_pkg::CNT_W-1:0] cnt;
  wire cnt_end = (cnt == fca_pkg::CNT_W'(fca_pkg::PHASE_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CY_IDLE;
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      fl_addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      cnt <= cnt_end ? '0 : cnt + 1'b1;
      unique case (state)
        CY_IDLE: begin
          cnt <= '0;
          if (start) begin
            // address settles before either strobe falls
            fl_addr <= addr;
            dq_out <= wdata;
            dq_oe <= is_write;
            busy <= 1'b1;
            oe_n <= 1'b1;
            state <= CY_SETUP;
          end
        end
        CY_SETUP: if (cnt_end) begin
          // write only with ce and we low and oe high
          ce_n <= 1'b0;
          we_n <= !dq_oe;
          oe_n <= dq_oe;
          state <= CY_STROBE;
        end
        CY_STROBE: if (cnt_end) begin
          // data held stable across the rising edge of we
          if (!dq_oe) rdata <= dq_in;
          ce_n <= 1'b1;
          we_n <= 1'b1;
          oe_n <= 1'b1;
          state <= CY_HOLD;
        end
        CY_HOLD: if (cnt_end) begin
          dq_oe <= 1'b0;
          busy <= 1'b0;
          done <= 1'b1;
          state <= CY_IDLE;
        end
      endcase
    end
  end
endmodule : fca_cycle

//--- core/fca_host.sv
// apb-controlled host that drives the flash pins for identification and reset commands
//
// Overview of operation
// - host writes reset to leave identification
// - two unlocks then identification command
// - high voltage on line nine, six low
// - protect all before first unprotect cycle (left to software; the host only drives reset_hv)
// - write only ce, we low, oe high
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module fca_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [fca_pkg::DW-1:0] dq_in,
  output logic [fca_pkg::DW-1:0] dq_out,
  output logic dq_oe,
  output logic [fca_pkg::AW-1:0] fl_addr,
  output fca_pkg::fca_strobe_t strobes
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    HS_IDLE, HS_ISSUE, HS_WAIT, HS_DONE
  } fca_hs_t;
  fca_hs_t state;
  logic [31:0] ctrl_reg;
  logic [fca_pkg::AW-1:0] addr_reg;
  logic [fca_pkg::DW-1:0] wdata_reg;
  logic [fca_pkg::DW-1:0] rdata_reg;
  logic [2:0] pins_reg;
  logic busy;
  logic done_flag;
  logic [1:0] step;
  logic [1:0] last_step;
  logic cyc_start;
  logic cyc_write;
  logic [fca_pkg::AW-1:0] cyc_addr;
  logic [fca_pkg::DW-1:0] cyc_wdata;
  logic cyc_busy;
  logic cyc_done;
  logic [fca_pkg::DW-1:0] cyc_rdata;
  logic cyc_ce_n;
  logic cyc_we_n;
  logic cyc_oe_n;
  logic [fca_pkg::AW-1:0] cyc_fl_addr;
  logic [fca_pkg::DW-1:0] cyc_dq_out;
  logic cyc_dq_oe;
  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire wr_en = psel && penable && pwrite;
  // read data is registered in setup so it stands through the access phase
  wire rd_setup = psel && !penable && !pwrite;
  wire hit_ctrl = (paddr == fca_pkg::REG_CTRL);
  wire hit_addr = (paddr == fca_pkg::REG_ADDR);
  wire hit_wdata = (paddr == fca_pkg::REG_WDATA);
  wire hit_stat = (paddr == fca_pkg::REG_STATUS);
  wire hit_rdata = (paddr == fca_pkg::REG_RDATA);
  wire hit_pins = (paddr == fca_pkg::REG_PINS);
  // unmapped offsets answer zero together with the error flag
  wire hit_any = hit_ctrl | hit_addr | hit_wdata | hit_stat | hit_rdata | hit_pins;
  wire go = wr_en && hit_ctrl && pwdata[fca_pkg::CTRL_GO_LSB] && !busy;
  wire [2:0] op_bits = ctrl_reg[fca_pkg::CTRL_OP_LSB +: fca_pkg::CTRL_OP_W];
  wire word_mode = ctrl_reg[fca_pkg::CTRL_WORD_BIT];
  wire prot_hit = (rdata_reg[7:0] == fca_pkg::ID_PROT_YES);
  wire [31:0] stat_word = {28'h0, prot_hit, 1'b0, done_flag, busy};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_reg :
                       hit_addr ? {12'h0, addr_reg} :
                       hit_wdata ? {16'h0, wdata_reg} :
                       hit_stat ? stat_word :
                       hit_rdata ? {16'h0, rdata_reg} :
                       hit_pins ? {29'h0, pins_reg} : 32'h0;
  ////////////////////////////////////////////////////////////////////////////
  // sequence step address/data selection
  wire [fca_pkg::AW-1:0] unl1_a = fca_pkg::AW'(fca_pkg::UNLOCK1_ADDR);
  wire [fca_pkg::AW-1:0] unl2_a = fca_pkg::AW'(fca_pkg::UNLOCK2_ADDR);
  // identification select offset, word or byte mode
  wire [7:0] id_ofs = (addr_reg[1:0] == 2'd1) ? (word_mode ? fca_pkg::ID_DEV_OFS_WORD : fca_pkg::ID_DEV_OFS_BYTE) :
                      (addr_reg[1:0] == 2'd2) ? (word_mode ? fca_pkg::ID_PROT_OFS_WORD : fca_pkg::ID_PROT_OFS_BYTE) :
                      fca_pkg::ID_MAN_OFS;
  wire is_enter = (op_bits == 3'(fca_pkg::FCA_OP_IDENT_ENTER));
  wire is_reset = (op_bits == 3'(fca_pkg::FCA_OP_RESET_CMD));
  wire is_idrd = (op_bits == 3'(fca_pkg::FCA_OP_IDENT_READ));
  wire is_wr = (op_bits == 3'(fca_pkg::FCA_OP_WRITE));
  // two unlocks then identification command
  assign cyc_addr = is_enter ? (step == 2'd0 ? unl1_a : step == 2'd1 ? unl2_a : unl1_a) :
                    is_idrd ? {addr_reg[fca_pkg::AW-1:8], id_ofs} : addr_reg;
  assign cyc_wdata = is_enter ? {8'h0, (step == 2'd0 ? fca_pkg::UNLOCK1_DATA :
                                        step == 2'd1 ? fca_pkg::UNLOCK2_DATA : fca_pkg::CMD_IDENT)} :
                     is_reset ? {8'h0, fca_pkg::CMD_RESET} : wdata_reg;
  assign cyc_write = is_enter | is_reset | is_wr;
  assign last_step = is_enter ? 2'd2 : 2'd0;
  ////////////////////////////////////////////////////////////////////////////
  // apb slave registers; writes to ctrl while busy are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= fca_pkg::CTRL_RST;
      addr_reg <= '0;
      wdata_reg <= '0;
      pins_reg <= fca_pkg::PINS_RST[2:0];
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // zero wait: ready pulses in the first access cycle
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      if (rd_setup) prdata <= rd_mux;
      if (wr_en && hit_ctrl && !busy) ctrl_reg <= pwdata & 32'h0000_001E;
      if (wr_en && hit_addr) addr_reg <= pwdata[fca_pkg::AW-1:0];
      if (wr_en && hit_wdata) wdata_reg <= pwdata[fca_pkg::DW-1:0];
      // reset_hv is a bare request; software protects every sector before any unprotect
      if (wr_en && hit_pins) pins_reg <= pwdata[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // operation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HS_IDLE;
      step <= '0;
      busy <= 1'b0;
      done_flag <= 1'b0;
      cyc_start <= 1'b0;
      rdata_reg <= '0;
    end else begin
      cyc_start <= 1'b0;
      unique case (state)
        HS_IDLE: if (go) begin
          // reset command ends identification mode
          busy <= 1'b1;
          done_flag <= 1'b0;
          step <= '0;
          state <= HS_ISSUE;
        end
        // the cycle engine must be idle before the next start
        HS_ISSUE: if (!cyc_busy) begin
          cyc_start <= 1'b1;
          state <= HS_WAIT;
        end
        HS_WAIT: if (cyc_done) begin
          // read result also feeds the status protect bit
          if (!cyc_write) rdata_reg <= cyc_rdata;
          if (step == last_step) begin
            state <= HS_DONE;
          end else begin
            step <= step + 2'd1;
            state <= HS_ISSUE;
          end
        end
        HS_DONE: begin
          busy <= 1'b0;
          done_flag <= 1'b1;
          state <= HS_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  fca_cycle u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .dq_in(dq_in),
    .busy(cyc_busy),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(cyc_fl_addr),
    .dq_out(cyc_dq_out),
    .dq_oe(cyc_dq_oe),
    .ce_n(cyc_ce_n),
    .we_n(cyc_we_n),
    .oe_n(cyc_oe_n)
  );
  // pin outputs straight from flops; reset pin and high-voltage controls from pins reg
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobes <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, reset_n: 1'b0, a9_hv: 1'b0, reset_hv: 1'b0};
      fl_addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
    end else begin
      // all pins share one flop stage so they move on the same edge
      strobes.ce_n <= cyc_ce_n;
      strobes.we_n <= cyc_we_n;
      strobes.oe_n <= cyc_oe_n;
      strobes.reset_n <= pins_reg[fca_pkg::PINS_RST_BIT];
      strobes.a9_hv <= pins_reg[fca_pkg::PINS_A9HV_BIT];
      strobes.reset_hv <= pins_reg[fca_pkg::PINS_RSTHV_BIT];
      // high-voltage identification keeps line six low
      fl_addr <= pins_reg[fca_pkg::PINS_A9HV_BIT] ? (cyc_fl_addr & ~fca_pkg::AW'(64)) : cyc_fl_addr;
      dq_out <= cyc_dq_out;
      dq_oe <= cyc_dq_oe;
    end
  end
endmodule : fca_host

//--- dv/fca_host_properties.sv
// port checker for the flash host controller
`timescale 1ns/1ps
module fca_host_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dq_oe,
  input wire logic [fca_pkg::DW-1:0] dq_out,
  input wire logic [fca_pkg::AW-1:0] fl_addr,
  input wire fca_pkg::fca_strobe_t strobes
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr_low; !strobes.we_n [*4]; endsequence
  sequence s_data_held; dq_oe && $stable(dq_out); endsequence
  property p_wr_oe; !strobes.ce_n && !strobes.we_n |-> strobes.oe_n; endproperty
  property p_rd_float; !strobes.oe_n |-> !dq_oe; endproperty
  property p_wr_len; $fell(strobes.we_n) |-> s_wr_low; endproperty
  property p_addr_hold; !strobes.we_n |-> $stable(fl_addr); endproperty
  property p_data_hold; $rose(strobes.we_n) |-> s_data_held; endproperty
  property p_a6_low; strobes.a9_hv |-> !fl_addr[6]; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_zero_wait; psel && !penable |=> pready; endproperty
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("write with oe low");
  a_rd_float: assert property (p_rd_float) else $error("bus contention");
  a_wr_len: assert property (p_wr_len) else $error("short write pulse");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  a_data_hold: assert property (p_data_hold) else $error("data moved");
  a_a6_low: assert property (p_a6_low) else $error("line six high");
  a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
  a_zero_wait: assert property (p_zero_wait) else $error("late ready");
  a_err: assert property (p_err) else $error("stray error");
endmodule : fca_host_properties
bind fca_host fca_host_properties u_fca_host_properties (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .dq_oe, .dq_out, .fl_addr, .strobes);

//--- dv/fca_flash_model.sv
// behavioural flash device for command and identification cycles
`timescale 1ns/1ps
module fca_flash_model #(
  parameter logic [7:0] MAN_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC5 // arbitrary value
) (
  input wire logic [fca_pkg::AW-1:0] fl_addr,
  input wire logic [fca_pkg::DW-1:0] dq_out,
  input wire fca_pkg::fca_strobe_t strobes,
  output logic [fca_pkg::DW-1:0] dq_in
);
  logic [1:0] st = 2'h0;
  logic prot [256] = '{default: 1'b0};
  logic [19:0] lat_a = 20'h00000;
  logic [15:0] rd;
  logic [15:0] last = 16'h0000;
  // program, erase, suspend, lockout and power-up inhibit are not modelled
  wire wr = !strobes.ce_n && !strobes.we_n && strobes.oe_n && strobes.reset_n;
  wire drv = !strobes.ce_n && !strobes.oe_n && strobes.reset_n;
  wire id = st == 2'h3 || (strobes.a9_hv && !fl_addr[6]);
  function automatic logic ok(input logic [15:0] a, input logic [7:0] d);
    return lat_a[15:0] === a && dq_out[7:0] === d;
  endfunction : ok
  task automatic set_prot(input int s);
    prot[s] = 1'b1;
  endtask : set_prot
  always @(posedge wr) lat_a = fl_addr;
  always @(negedge wr or negedge strobes.reset_n) begin
    if (!strobes.reset_n) st = 2'h0;
    else if (dq_out[7:0] === fca_pkg::CMD_RESET) st = 2'h0;
    else if (st != 2'h3) st = (st == 2'h0 && ok(fca_pkg::UNLOCK1_ADDR, fca_pkg::UNLOCK1_DATA)) ? 2'h1 :
      (st == 2'h1 && ok(fca_pkg::UNLOCK2_ADDR, fca_pkg::UNLOCK2_DATA)) ? 2'h2 :
      (st == 2'h2 && ok(fca_pkg::UNLOCK1_ADDR, fca_pkg::CMD_IDENT)) ? 2'h3 : 2'h0;
  end
  assign rd = !id ? fl_addr[15:0] ^ 16'h5A5A :
    fl_addr[7:0] == 8'h00 ? {8'h00, MAN_CODE} :
    fl_addr[7:0] == 8'h01 ? {8'h00, DEV_CODE} :
    fl_addr[7:0] == 8'h02 ? {15'h0000, prot[fl_addr[19:12]]} : 16'h0000;
  always @* if (drv) last = rd;
  assign dq_in = drv ? rd : ~last;
endmodule : fca_flash_model

//--- dv/fca_host_tb_top.sv
// testbench for the flash host controller
`timescale 1ns/1ps
module fca_host_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd, stat;
  logic pready, pslverr, dq_oe, err;
  logic [15:0] dq_in, dq_out;
  logic [19:0] fl_addr;
  fca_pkg::fca_strobe_t strobes;
  int mismatches = 0;
  int checks = 0;
  localparam logic [15:0] ARR0 = 16'h5A5A;
  initial begin
    forever #5 pclk = ~pclk;
  end
  fca_host u_fca_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .dq_in, .dq_out, .dq_oe, .fl_addr, .strobes);
  fca_flash_model u_fca_flash_model (.fl_addr, .dq_out, .strobes, .dq_in);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      $display("wrong value at %0t: no ready", $time);
      mismatches++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic op(input fca_pkg::fca_op_t code, input logic [19:0] a, input logic [15:0] d,
                    input logic wm = 1'b1);
    int n;
    n = 0;
    apb(1'b1, fca_pkg::REG_ADDR, {12'h000, a});
    apb(1'b1, fca_pkg::REG_WDATA, {16'h0000, d});
    apb(1'b1, fca_pkg::REG_CTRL, {27'h0, wm, code, 1'b1});
    do begin
      apb(1'b0, fca_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 500);
    if (rd[1] !== 1'b1) begin
      $display("wrong value at %0t: no done", $time);
      mismatches++;
      conclude();
    end
    stat = rd;
    apb(1'b0, fca_pkg::REG_RDATA, 32'h0);
  endtask : op
  task automatic s_regs;
    apb(1'b0, fca_pkg::REG_CTRL, 32'h0);
    check(rd, fca_pkg::CTRL_RST);
    apb(1'b0, fca_pkg::REG_PINS, 32'h0);
    check(rd, fca_pkg::PINS_RST);
    apb(1'b1, fca_pkg::REG_PINS, 32'h00000005);
    apb(1'b0, fca_pkg::REG_PINS, 32'h0);
    check(rd, 32'h00000005);
    apb(1'b1, fca_pkg::REG_PINS, fca_pkg::PINS_RST);
    apb(1'b0, 8'h18, 32'h0);
    check({rd[30:0], err}, 32'h00000001);
  endtask : s_regs
  task automatic s_ident;
    op(fca_pkg::FCA_OP_READ, 20'h01234, 16'h0000);
    check(rd[15:0], 16'h1234 ^ ARR0);
    op(fca_pkg::FCA_OP_IDENT_ENTER, 20'h00000, 16'h0000);
    op(fca_pkg::FCA_OP_IDENT_READ, 20'h00000, 16'h0000);
    check(rd[7:0], u_fca_flash_model.MAN_CODE);
    op(fca_pkg::FCA_OP_IDENT_READ, 20'h00001, 16'h0000);
    check(rd[7:0], u_fca_flash_model.DEV_CODE);
    op(fca_pkg::FCA_OP_IDENT_READ, 20'h35002, 16'h0000);
    check({rd[7:0], stat[3]}, {8'h00, 1'b0});
    u_fca_flash_model.set_prot(8'h35);
    op(fca_pkg::FCA_OP_IDENT_READ, 20'h35002, 16'h0000);
    check({rd[7:0], stat[3]}, {fca_pkg::ID_PROT_YES, 1'b1});
    // byte mode puts the device code at offset two, the word-mode protect slot of the model
    op(fca_pkg::FCA_OP_IDENT_READ, 20'h35001, 16'h0000, 1'b0);
    check(rd[7:0], fca_pkg::ID_PROT_YES);
    op(fca_pkg::FCA_OP_READ, 20'h00000, 16'h0000);
    check(rd[7:0], u_fca_flash_model.MAN_CODE);
    op(fca_pkg::FCA_OP_RESET_CMD, 20'h7ABCD, 16'h0000);
    op(fca_pkg::FCA_OP_READ, 20'h00000, 16'h0000);
    check(rd[15:0], ARR0);
  endtask : s_ident
  task automatic s_abort;
    op(fca_pkg::FCA_OP_WRITE, 20'h00555, 16'h00AA);
    op(fca_pkg::FCA_OP_WRITE, 20'h002AA, 16'h0066);
    op(fca_pkg::FCA_OP_WRITE, 20'h00555, 16'h0090);
    op(fca_pkg::FCA_OP_READ, 20'h00000, 16'h0000);
    check(rd[15:0], ARR0);
  endtask : s_abort
  task automatic s_pins;
    apb(1'b1, fca_pkg::REG_PINS, 32'h00000003);
    op(fca_pkg::FCA_OP_READ, 20'h00041, 16'h0000);
    check(rd[7:0], u_fca_flash_model.DEV_CODE);
    apb(1'b1, fca_pkg::REG_PINS, fca_pkg::PINS_RST);
    op(fca_pkg::FCA_OP_IDENT_ENTER, 20'h00000, 16'h0000);
    apb(1'b1, fca_pkg::REG_PINS, 32'h00000000);
    apb(1'b1, fca_pkg::REG_PINS, fca_pkg::PINS_RST);
    op(fca_pkg::FCA_OP_READ, 20'h00000, 16'h0000);
    check(rd[15:0], ARR0);
  endtask : s_pins
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs();
    s_ident();
    s_abort();
    s_pins();
    conclude();
  end
  initial begin
    #300000;
    mismatches++;
    conclude();
  end
endmodule : fca_host_tb_top
